// ===== src/tx_descriptor_list_walker.v
// transmit descriptor list walker for one dma channel, with receive write-back
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "tx_walker_consts.vh"
module tx_descriptor_list_walker (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // shared memory master
  output reg mem_req,
  output reg mem_we,
  output reg mem_burst,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // transmit fifo
  output wire fifo_valid,
  output wire [7:0] fifo_data,
  output wire fifo_end,
  output wire fifo_nodata,
  input wire fifo_ready,
  // interrupt events
  output reg irq_hi,
  output reg irq_err,
  // receive write-back request
  input wire rx_wb_req,
  input wire [31:0] rx_wb_addr,
  input wire [31:0] rx_wb_status,
  input wire [31:0] rx_wb_feptr,
  input wire rx_wb_first,
  output reg rx_wb_done
);
  reg [3:0] state_r, state_nxt;
  reg chain_mode_select_r;
  reg [31:0] base_r, last_r, cur_r;
  reg last_new_r;
  reg hold_stop_r;
  reg ev_hi_r, ev_err_r;
  reg [1:0] widx_r;
  reg fe_r, hold_r, hi_r, abort_r;
  reg [`TXD_CNT_W-1:0] cnt_r;
  reg [31:0] dp_r;
  reg rx_idx_r;
  reg [31:0] rx_addr_r, rx_stat_r, rx_fe_r;
  reg rx_first_r;

  wire wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
  wire wr_cmd = reg_wr && (reg_addr == `REG_CMD);
  wire wr_last = reg_wr && (reg_addr == `REG_LAST);
  wire wr_stat = reg_wr && (reg_addr == `REG_STATUS);
  wire cmd_init = wr_cmd && reg_wdata[`CMD_INIT_BIT];
  wire cmd_poll = wr_cmd && reg_wdata[`CMD_POLL_BIT];
  wire cmd_rst = wr_cmd && reg_wdata[`CMD_TXRST_BIT];
  wire in_data = (state_r == `ST_RD) || (state_r == `ST_PUSH) || (state_r == `ST_MARK);
  wire rx_state = (state_r == `ST_RXW);

  // descriptor storage
  wire [31:0] desc_rdata;
  wire desc_wr = (state_r == `ST_FETCH) && mem_ack;
  reg desc_rd;
  reg [1:0] desc_ridx;
  always @* begin
    desc_rd = 1'b0;
    desc_ridx = `TXD_W0_IDX;
    case (state_r)
      `ST_LD0: begin
        desc_rd = 1'b1;
      end
      `ST_LD2: begin
        desc_rd = 1'b1;
        desc_ridx = `TXD_W2_IDX;
      end
      `ST_BR1: begin
        desc_rd = 1'b1;
        desc_ridx = `TXD_W1_IDX;
      end
      default: begin
        desc_rd = 1'b0;
      end
    endcase
  end
  desc_store #(.WIDTH(32), .DEPTH(4), .AW(2)) u_store (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(desc_wr),
    .wr_idx(widx_r),
    .wr_data(mem_rdata),
    .rd_en(desc_rd),
    .rd_idx(desc_ridx),
    .rd_data(desc_rdata)
  );

  // byte picking for unaligned data sections
  wire push_ok = (state_r == `ST_PUSH) && fifo_ready;
  wire lane_load = (state_r == `ST_RD) && mem_ack;
  wire lane_step = push_ok && (cnt_r != 13'h0001) && (dp_r[1:0] != 2'h3);
  wire [1:0] lane_sel = lane_load ? dp_r[1:0] : dp_r[1:0] + 2'h1;
  byte_lane_pick #(.LANES(4)) u_pick (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(lane_load),
    .step(lane_step),
    .sel(lane_sel),
    .word(mem_rdata),
    .byte_out(fifo_data)
  );

  assign fifo_valid = (state_r == `ST_PUSH) || (state_r == `ST_MARK);
  assign fifo_end = fe_r && (((state_r == `ST_PUSH) && (cnt_r == 13'h0001)) || (state_r == `ST_MARK));
  assign fifo_nodata = (state_r == `ST_MARK);

  // memory requests are held until acknowledged, unless an init or reset command redirects the channel first
  always @* begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_burst = 1'b0;
    mem_addr = 32'h00000000;
    mem_wdata = 32'h00000000;
    case (state_r)
      `ST_FETCH: begin
        mem_req = 1'b1;
        mem_burst = 1'b1;
        mem_addr = cur_r + {28'h0000000, widx_r, 2'h0};
      end
      `ST_RD: begin
        mem_req = 1'b1;
        mem_addr = {dp_r[31:2], 2'h0};
      end
      `ST_WB: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = cur_r + `TXD_W3_OFS;
        mem_wdata = `TXD_C_WORD;
      end
      `ST_RXW: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = rx_addr_r + (rx_idx_r ? `RXD_W4_OFS : `RXD_W3_OFS);
        mem_wdata = rx_idx_r ? rx_fe_r : rx_stat_r;
      end
      default: begin
        mem_req = 1'b0;
      end
    endcase
  end

  // channel sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE: begin
        if (rx_wb_req) begin
          state_nxt = `ST_RXW;
        end else if (cmd_poll) begin
          state_nxt = `ST_FETCH;
        end
      end
      `ST_FETCH: begin
        if (mem_ack && (widx_r == `TXD_READ_WORDS - 2'h1)) begin
          state_nxt = `ST_LD0;
        end
      end
      `ST_LD0: state_nxt = `ST_LD2;
      `ST_LD2: state_nxt = `ST_LDC;
      `ST_LDC: state_nxt = `ST_CHECK;
      `ST_CHECK: begin
        if (cnt_r != 13'h0000) begin
          state_nxt = `ST_RD;
        end else if (fe_r) begin
          state_nxt = `ST_MARK;
        end else begin
          state_nxt = `ST_WB;
        end
      end
      `ST_RD: begin
        if (mem_ack) begin
          state_nxt = `ST_PUSH;
        end
      end
      `ST_PUSH: begin
        if (fifo_ready) begin
          if (cnt_r == 13'h0001) begin
            state_nxt = `ST_WB;
          end else if (dp_r[1:0] == 2'h3) begin
            state_nxt = `ST_RD;
          end
        end
      end
      `ST_MARK: begin
        if (fifo_ready) begin
          state_nxt = `ST_WB;
        end
      end
      `ST_WB: begin
        if (mem_ack) begin
          state_nxt = abort_r ? `ST_IDLE : `ST_DECIDE;
        end
      end
      `ST_DECIDE: begin
        if (!fe_r) begin
          state_nxt = `ST_BR1;
        end else if (!chain_mode_select_r) begin
          state_nxt = hold_r ? `ST_HOLD : `ST_BR1;
        end else begin
          state_nxt = (cur_r == last_r) ? `ST_AWAIT : `ST_BR1;
        end
      end
      `ST_BR1: state_nxt = `ST_BRC;
      `ST_BRC: state_nxt = `ST_FETCH;
      `ST_HOLD: begin
        if (rx_wb_req) begin
          state_nxt = `ST_RXW;
        end else if (cmd_poll) begin
          state_nxt = `ST_BR1;
        end
      end
      `ST_AWAIT: begin
        if (rx_wb_req) begin
          state_nxt = `ST_RXW;
        end else if (last_new_r) begin
          state_nxt = `ST_DECIDE;
        end
      end
      `ST_RXW: begin
        if (mem_ack && (rx_idx_r || !rx_first_r)) begin
          state_nxt = `ST_IDLE;
        end
      end
      default: state_nxt = `ST_IDLE;
    endcase
    // commands override the walk, except while a receive write-back is in flight
    if (!rx_state) begin
      if (cmd_init) begin
        state_nxt = `ST_FETCH;
      end else if (cmd_rst) begin
        state_nxt = in_data ? `ST_WB : `ST_IDLE;
      end
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= `ST_IDLE;
      chain_mode_select_r <= `CTRL_RST;
      base_r <= `ADDR_RST;
      last_r <= `ADDR_RST;
      cur_r <= `ADDR_RST;
      last_new_r <= 1'b0;
      hold_stop_r <= 1'b0;
      ev_hi_r <= 1'b0;
      ev_err_r <= 1'b0;
      widx_r <= 2'h0;
      fe_r <= 1'b0;
      hold_r <= 1'b0;
      hi_r <= 1'b0;
      abort_r <= 1'b0;
      cnt_r <= 13'h0000;
      dp_r <= 32'h00000000;
      irq_hi <= 1'b0;
      irq_err <= 1'b0;
      rx_idx_r <= 1'b0;
      rx_addr_r <= 32'h00000000;
      rx_stat_r <= 32'h00000000;
      rx_fe_r <= 32'h00000000;
      rx_first_r <= 1'b0;
      rx_wb_done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      irq_hi <= 1'b0;
      irq_err <= 1'b0;
      rx_wb_done <= 1'b0;
      if (wr_ctrl) begin
        chain_mode_select_r <= reg_wdata[`CTRL_CHAIN_BIT];
      end
      if (reg_wr && (reg_addr == `REG_BASE)) begin
        base_r <= reg_wdata;
        // a channel not yet walking starts its next poll from the new base
        if (state_r == `ST_IDLE) begin
          cur_r <= reg_wdata;
        end
      end
      if (wr_last) begin
        last_r <= reg_wdata;
      end
      // a fresh last address wins over the clear on leaving the wait
      if (wr_last) begin
        last_new_r <= 1'b1;
      end else if (state_r == `ST_AWAIT) begin
        last_new_r <= 1'b0;
      end
      hold_stop_r <= (state_nxt == `ST_HOLD);
      if ((state_r == `ST_FETCH) && mem_ack) begin
        widx_r <= widx_r + 2'h1;
      end
      if (state_nxt == `ST_FETCH && state_r != `ST_FETCH) begin
        widx_r <= 2'h0;
      end
      if (state_r == `ST_LD2) begin
        fe_r <= desc_rdata[`TXD_FE_BIT];
        hold_r <= desc_rdata[`TXD_HOLD_BIT] && !chain_mode_select_r;
        hi_r <= desc_rdata[`TXD_HI_BIT];
        cnt_r <= desc_rdata[`TXD_CNT_MSB:`TXD_CNT_LSB];
      end
      if (state_r == `ST_LDC) begin
        dp_r <= desc_rdata;
      end
      if ((state_r == `ST_CHECK) && (cnt_r == 13'h0000) && !fe_r) begin
        irq_err <= 1'b1;
      end
      if (push_ok) begin
        dp_r <= dp_r + 32'h00000001;
        cnt_r <= cnt_r - 13'h0001;
      end
      if (hi_r && ((push_ok && (cnt_r == 13'h0001)) || ((state_r == `ST_MARK) && fifo_ready))) begin
        irq_hi <= 1'b1;
      end
      if (state_r == `ST_BRC) begin
        cur_r <= desc_rdata;
      end
      // an aborted section keeps its address until its complete flag is written
      if ((state_r == `ST_WB) && mem_ack && abort_r) begin
        abort_r <= 1'b0;
        cur_r <= base_r;
      end
      if (!rx_state && (cmd_init || cmd_rst)) begin
        if (cmd_init || !in_data) begin
          cur_r <= base_r;
        end
        abort_r <= cmd_rst && in_data && !cmd_init;
      end
      // sticky events: a new event wins over a software clear
      if (irq_hi) begin
        ev_hi_r <= 1'b1;
      end else if (wr_stat && reg_wdata[`STAT_HI_BIT]) begin
        ev_hi_r <= 1'b0;
      end
      if (irq_err) begin
        ev_err_r <= 1'b1;
      end else if (wr_stat && reg_wdata[`STAT_ERR_BIT]) begin
        ev_err_r <= 1'b0;
      end
      if ((state_nxt == `ST_RXW) && !rx_state) begin
        rx_idx_r <= 1'b0;
        rx_addr_r <= {rx_wb_addr[31:2], 2'h0};
        rx_stat_r <= rx_wb_status;
        rx_fe_r <= rx_wb_feptr;
        rx_first_r <= rx_wb_first;
      end
      if (rx_state && mem_ack) begin
        rx_idx_r <= 1'b1;
        if (rx_idx_r || !rx_first_r) begin
          rx_wb_done <= 1'b1;
        end
      end
    end
  end

  // register read port, data in the cycle after the strobe
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {31'h00000000, chain_mode_select_r};
        `REG_BASE: reg_rdata <= base_r;
        `REG_LAST: reg_rdata <= last_r;
        `REG_STATUS: reg_rdata <= {22'h000000, ev_err_r, ev_hi_r, 2'h0, hold_stop_r, 1'b0, state_r};
        `REG_CUR: reg_rdata <= cur_r;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// ===== include/tx_walker_consts.vh
// constants for the transmit descriptor list walker
`ifndef TX_WALKER_CONSTS_VH
`define TX_WALKER_CONSTS_VH
// transmit descriptor layout
`define TXD_WORDS 3'h4
`define TXD_READ_WORDS 2'h3
`define TXD_W0_IDX 2'h0
`define TXD_W1_IDX 2'h1
`define TXD_W2_IDX 2'h2
`define TXD_W3_OFS 32'h0000000C
`define TXD_FE_BIT 31
`define TXD_HOLD_BIT 30
`define TXD_HI_BIT 29
`define TXD_CNT_MSB 28
`define TXD_CNT_LSB 16
`define TXD_CNT_W 13
`define TXD_CNT_MAX 13'h1FFF
`define TXD_C_WORD 32'h40000000
// receive descriptor layout
`define RXD_WORDS 3'h5
`define RXD_READ_WORDS 2'h3
`define RXD_W3_OFS 32'h0000000C
`define RXD_W4_OFS 32'h00000010
// register offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_BASE 8'h08
`define REG_LAST 8'h0C
`define REG_STATUS 8'h10
`define REG_CUR 8'h14
// register fields
`define CTRL_CHAIN_BIT 0
`define CMD_INIT_BIT 0
`define CMD_POLL_BIT 1
`define CMD_TXRST_BIT 2
`define STAT_HOLD_BIT 5
`define STAT_HI_BIT 8
`define STAT_ERR_BIT 9
// reset values
`define CTRL_RST 1'h0
`define ADDR_RST 32'h00000000
// channel states
`define ST_IDLE 4'h0
`define ST_FETCH 4'h1
`define ST_LD0 4'h2
`define ST_LD2 4'h3
`define ST_LDC 4'h4
`define ST_CHECK 4'h5
`define ST_RD 4'h6
`define ST_PUSH 4'h7
`define ST_MARK 4'h8
`define ST_WB 4'h9
`define ST_DECIDE 4'hA
`define ST_BR1 4'hB
`define ST_BRC 4'hC
`define ST_HOLD 4'hD
`define ST_AWAIT 4'hE
`define ST_RXW 4'hF
`endif

// ===== src/desc_store.v
// on-chip storage for the words of the current descriptor
`timescale 1ns/10ps
module desc_store #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_idx,
  input wire [WIDTH-1:0] wr_data,
  // read port, data one cycle later
  input wire rd_en,
  input wire [AW-1:0] rd_idx,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule

// ===== src/byte_lane_pick.v
// holds one fetched long word and presents one byte lane from a register
`timescale 1ns/10ps
module byte_lane_pick #(
  parameter LANES = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // control
  input wire load,
  input wire step,
  input wire [1:0] sel,
  input wire [8*LANES-1:0] word,
  // byte out
  output reg [7:0] byte_out
);
  reg [8*LANES-1:0] word_r;
  wire [8*LANES-1:0] src = load ? word : word_r;
  wire [7:0] lane [0:LANES-1];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lanes
      assign lane[g] = src[8*g+7:8*g];
    end
  endgenerate
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      word_r <= {8*LANES{1'b0}};
      byte_out <= 8'h00;
    end else begin
      if (load) begin
        word_r <= word;
      end
      if (load || step) begin
        byte_out <= lane[sel];
      end
    end
  end
endmodule

// ===== tb/walker_properties.sv
// concurrent checks on the ports of the descriptor list walker
`timescale 1ns/10ps
module walker_properties (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // memory master
  input logic mem_req,
  input logic mem_we,
  input logic mem_burst,
  input logic [31:0] mem_addr,
  input logic [31:0] mem_wdata,
  input logic mem_ack,
  // fifo, events and receive write-back
  input logic fifo_valid,
  input logic fifo_ready,
  input logic [7:0] fifo_data,
  input logic fifo_end,
  input logic fifo_nodata,
  input logic irq_hi,
  input logic irq_err,
  input logic rx_wb_req,
  input logic rx_wb_done
);
  logic rx_act_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // a receive write-back runs from its request to its done pulse
  always @(posedge ref_clk or posedge reset) begin
    if (reset) rx_act_r <= 1'b0;
    else if (rx_wb_done) rx_act_r <= 1'b0;
    else if (rx_wb_req) rx_act_r <= 1'b1;
  end
  // a command write may abandon a request, so those cycles are left out
  sequence s_wait; mem_req && !mem_ack && !reg_wr; endsequence
  sequence s_beat; mem_req && mem_burst && mem_ack && !reg_wr ##1 mem_req && mem_burst; endsequence
  sequence s_offer; fifo_valid && !fifo_ready && !reg_wr; endsequence
  a_rdata_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  a_req_held: assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request dropped or changed");
  a_burst_step: assert property (s_beat |-> mem_addr == $past(mem_addr) + 32'h4)
    else $error("descriptor words not consecutive");
  a_burst_reads: assert property (mem_req && mem_burst |-> !mem_we)
    else $error("burst used for a write");
  a_data_aligned: assert property (mem_req && !mem_we && !mem_burst |-> mem_addr[1:0] == 2'h0)
    else $error("data read not on a long word");
  a_c_word: assert property (mem_req && mem_we && !rx_wb_req && !rx_act_r |-> mem_wdata == 32'h40000000)
    else $error("write-back word wrong");
  a_rx_done: assert property (rx_wb_done |-> $past(mem_ack && mem_we))
    else $error("done without a finished write");
  a_hi_pulse: assert property (irq_hi |=> !irq_hi)
    else $error("host interrupt longer than one cycle");
  a_err_pulse: assert property (irq_err |=> !irq_err)
    else $error("error interrupt longer than one cycle");
  a_marker_end: assert property (fifo_valid && fifo_nodata |-> fifo_end)
    else $error("empty entry without frame end");
  a_fifo_held: assert property (s_offer |=> fifo_valid && $stable({fifo_data, fifo_end, fifo_nodata}))
    else $error("fifo entry changed before taken");
endmodule

// ===== tb/host_mem.sv
// shared host memory answering the walker's master port
`timescale 1ns/10ps
module host_mem (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // master port
  input logic mem_req,
  input logic mem_we,
  input logic [31:0] mem_addr,
  input logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // wait states before the answer
  input logic [1:0] lat
);
  logic [31:0] m [0:255];
  logic [1:0] cnt_r;
  assign mem_ack = mem_req && cnt_r >= lat;
  // inverted data outside the answer so stale words never pass
  assign mem_rdata = mem_ack ? m[mem_addr[9:2]] : ~m[mem_addr[9:2]];
  always @(posedge ref_clk or posedge reset) begin
    if (reset) cnt_r <= 2'h0;
    else if (mem_ack || !mem_req) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end
  always @(posedge ref_clk) begin
    if (mem_ack && mem_we) m[mem_addr[9:2]] <= mem_wdata;
  end
endmodule

// ===== tb/test_tx_descriptor_list_walker.sv
// self-checking bench for the transmit descriptor list walker
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module test_tx_descriptor_list_walker;
  logic ref_clk, reset, reg_wr, reg_rd, mem_req, mem_we, mem_burst, mem_ack, rd_d, stall;
  logic fifo_valid, fifo_end, fifo_nodata, fifo_ready, irq_hi, irq_err, rx_wb_req, rx_wb_first, rx_wb_done;
  logic [7:0] reg_addr, fifo_data;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, rx_wb_addr, rx_wb_status, rx_wb_feptr, a, old;
  logic [1:0] lat;
  logic [31:0] rexp;
  logic [9:0] fexp;
  integer n_errors, tests_run, seed, n_hi, n_err, i, k;
  logic [31:0] rq [$];
  logic [9:0] fq [$];
  tx_descriptor_list_walker u_tx_descriptor_list_walker (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_burst(mem_burst), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_end(fifo_end),
    .fifo_nodata(fifo_nodata), .fifo_ready(fifo_ready), .irq_hi(irq_hi), .irq_err(irq_err),
    .rx_wb_req(rx_wb_req), .rx_wb_addr(rx_wb_addr), .rx_wb_status(rx_wb_status), .rx_wb_feptr(rx_wb_feptr),
    .rx_wb_first(rx_wb_first), .rx_wb_done(rx_wb_done));
  host_mem u_host_mem (.ref_clk(ref_clk), .reset(reset), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // random wait states and fifo stalls
  always @(posedge ref_clk) begin
    lat <= $random(seed);
    fifo_ready <= ($random(seed) & 1) != 0 && !stall;
  end
  // results are compared against the oldest note
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (irq_hi === 1'b1) n_hi++;
    if (irq_err === 1'b1) n_err++;
    // take each note once, so a mismatch message does not pop a second one
    if (rd_d === 1'b1) begin
      rexp = rq.pop_front();
      `CHK(reg_rdata, rexp)
    end
    if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
      fexp = fq.pop_front();
      `CHK({fifo_nodata, fifo_end, fifo_nodata ? 8'h00 : fifo_data}, fexp)
    end
  end
  task wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // host lays out a full descriptor before any branch can reach it
  task desc(input logic [31:0] da, input logic [2:0] f, input logic [31:0] nx, dp, input logic [12:0] n);
    integer j;
    logic [31:0] b;
    u_host_mem.m[da[9:2]] = {f, n, 16'h0000};
    u_host_mem.m[da[9:2] + 1] = nx;
    u_host_mem.m[da[9:2] + 2] = dp;
    u_host_mem.m[da[9:2] + 3] = 32'h00000000;
    for (j = 0; j < n; j++) begin
      b = dp + j;
      fq.push_back({1'b0, f[2] && j == n - 1, u_host_mem.m[b[9:2]][8 * b[1:0] +: 8]});
    end
    if (n == 0 && f[2]) fq.push_back(10'h300);
  endtask
  task waitm(input logic [31:0] ad);
    integer j;
    for (j = 0; j < 500 && u_host_mem.m[ad[9:2]] !== 32'h40000000; j++) @(posedge ref_clk);
    `CHK(u_host_mem.m[ad[9:2]], 32'h40000000)
  endtask
  task close_out;
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    seed = 32'h2caead9d;
    {n_errors, tests_run, n_hi, n_err} = 0;
    {reset, stall} = 2'b10;
    {reg_wr, reg_rd, rx_wb_req, rx_wb_first, fifo_ready, lat} = 0;
    {reg_addr, reg_wdata, rx_wb_addr, rx_wb_status, rx_wb_feptr} = 0;
    for (i = 0; i < 256; i++) u_host_mem.m[i] = $random(seed);
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    // hold chaining: unaligned data, host interrupt, then stop on hold
    desc(32'h40, 3'b001, 32'h50, 32'h203, 13'h5);
    desc(32'h50, 3'b110, 32'h60, 32'h301, 13'h3);
    desc(32'h60, 3'b000, 32'h70, 32'h0, 13'h0);
    desc(32'h70, 3'b110, 32'h80, 32'h0, 13'h0);
    wr(8'h08, 32'h40);
    rd(8'h08, 32'h40);
    wr(8'h04, 32'h2);
    waitm(32'h4C);
    waitm(32'h5C);
    repeat (40) @(posedge ref_clk);
    `CHK(n_hi, 1)
    `CHK(n_err, 0)
    rd(8'h10, 32'h0000012D);
    wr(8'h04, 32'h2);
    waitm(32'h7C);
    `CHK(n_err, 1)
    `CHK(fq.size(), 0)
    wr(8'h10, 32'h00000300);
    rd(8'h10, 32'h0000002D);
    // address chaining: hold bit ignored, wait on last address
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    desc(32'h80, 3'b110, 32'h90, 32'h305, 13'h2);
    desc(32'h90, 3'b100, 32'hA0, 32'h311, 13'h1);
    desc(32'hA0, 3'b100, 32'hB0, 32'h315, 13'h2);
    wr(8'h0C, 32'h90);
    wr(8'h08, 32'h80);
    wr(8'h04, 32'h1);
    waitm(32'h9C);
    repeat (40) @(posedge ref_clk);
    `CHK(fq.size(), 2)
    rd(8'h14, 32'h90);
    wr(8'h0C, 32'hA0);
    waitm(32'hAC);
    `CHK(fq.size(), 0)
    // transmitter reset while the fifo stalls mid-section
    stall = 1'b1;
    desc(32'hB0, 3'b100, 32'hC0, 32'h321, 13'h4);
    wr(8'h08, 32'hB0);
    wr(8'h04, 32'h1);
    for (i = 0; i < 200 && fifo_valid !== 1'b1; i++) @(posedge ref_clk);
    `CHK(fifo_valid, 1'b1)
    wr(8'h08, 32'h40);
    wr(8'h04, 32'h4);
    waitm(32'hBC);
    rd(8'h14, 32'h40);
    fq.delete();
    stall = 1'b0;
    // receive write-back, first section and a later one
    for (k = 0; k < 2; k++) begin
      a = 32'hE0 + 32'h20 * k;
      old = u_host_mem.m[a[9:2] + 4];
      rx_wb_addr <= a;
      rx_wb_status <= $random(seed);
      rx_wb_feptr <= $random(seed);
      rx_wb_first <= (k == 0);
      rx_wb_req <= 1'b1;
      for (i = 0; i < 200 && !(mem_req === 1'b1 && mem_we === 1'b1); i++) @(posedge ref_clk);
      `CHK({mem_req, mem_we}, 2'b11)
      rx_wb_req <= 1'b0;
      for (i = 0; i < 200 && rx_wb_done !== 1'b1; i++) @(posedge ref_clk);
      `CHK(rx_wb_done, 1'b1)
      @(posedge ref_clk);
      `CHK(u_host_mem.m[a[9:2] + 3], rx_wb_status)
      `CHK(u_host_mem.m[a[9:2] + 4], k ? old : rx_wb_feptr)
    end
    close_out();
  end
endmodule
bind tx_descriptor_list_walker walker_properties u_walker_properties (.ref_clk(ref_clk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
  .mem_burst(mem_burst), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .fifo_valid(fifo_valid),
  .fifo_ready(fifo_ready), .fifo_data(fifo_data), .fifo_end(fifo_end), .fifo_nodata(fifo_nodata),
  .irq_hi(irq_hi), .irq_err(irq_err), .rx_wb_req(rx_wb_req), .rx_wb_done(rx_wb_done));
